//--- logic/video_rx_regs_defs.svh
`ifndef VIDEO_RX_REGS_DEFS_SVH
`define VIDEO_RX_REGS_DEFS_SVH
// Summary of operation
// - Twelve-bit screen height split over two registers, resetting to 0x2d0.
// - Read-only bit 5 shows link clock present, bit 6 data-enable activity.
// - Read-only bit 3 shows protection keys loaded successfully from nonvolatile memory.
// - Three-bit read-only link quality derived from data-enable edges.
// - Read-only bit 6 high while decryption of received video is active.
// - Read-only bit 5 is horizontal, bit 4 vertical sync polarity.
// - Detector pulse width maximum resets to 1001, minimum to 0110.
// - Oversample bit tells detector input is oversampled; pulse measurement scales.
// - Bit 6 of oversample register selects detector PAL mode.
// - Detector examines lines from start (reset 001101) to end (reset 010101).
// - Mode bit zero selects standard definition, one progressive; resets to one.
// - Override zero uses built-in counts and widths; one uses programmed values.
// - Standard definition only: two-bit pulse quota in last 3 lines, reset 10.
// - Bit 5 selects audio clock low-frequency mode; host uses below 80 MHz.
// - Low-frequency bit acts only with override bit 4 set; else automatic.

`define OFS_SCREEN_HEIGHT_HIGH     8'h2c
`define OFS_SCREEN_HEIGHT_LOW      8'h2d
`define OFS_TEST_CONTROL           8'h2e
`define OFS_LINK_STATUS            8'h2f
`define OFS_PROTECTION_SYNC_STATUS 8'h30
`define OFS_COPY_DETECT_PULSE      8'h31
`define OFS_COPY_DETECT_START      8'h32
`define OFS_COPY_DETECT_END        8'h33
`define OFS_PULSE_LIMIT_AUDIO      8'h34

`define RST_SCREEN_HEIGHT_HIGH     8'h02
`define RST_SCREEN_HEIGHT_LOW      8'hd0
`define RST_TEST_CONTROL           8'h00
`define RST_COPY_DETECT_PULSE      8'h96
`define RST_COPY_DETECT_START      8'h0d
`define RST_COPY_DETECT_END        8'h95
`define RST_PULSE_LIMIT_AUDIO      8'h80

`define POS_HEIGHT_HIGH            0
`define POS_TEST_ENABLE            7
`define POS_DE_SEEN                6
`define POS_CLOCK_PRESENT          5
`define POS_KEYS_LOADED            3
`define POS_QUALITY                0
`define POS_ENCRYPTED              6
`define POS_HSYNC_POLARITY         5
`define POS_VSYNC_POLARITY         4
`define POS_PULSE_MAX              4
`define POS_PULSE_MIN              0
`define POS_OVERSAMPLED            7
`define POS_PAL_MODE               6
`define POS_FIRST_LINE             0
`define POS_SCAN_MODE              7
`define POS_USE_PROGRAMMED         6
`define POS_LAST_LINE              0
`define POS_PULSE_QUOTA            6
`define POS_AUDIO_LOW_FREQ         5
`define POS_AUDIO_OVERRIDE         4

`define SERIAL_DEVICE_ADDR         7'h4c
`define QUALITY_WINDOW_CYCLES      16'h0400
`define QUALITY_MAX                3'h7
`endif

//--- logic/video_rx_regs_pkg.sv
package video_rx_regs_pkg;
	typedef enum logic [3:0] {
		SER_IDLE, SER_DEV_ADDR, SER_ADDR_ACK, SER_REG_ADDR, SER_REG_ACK,
		SER_WR_DATA, SER_WR_ACK, SER_RD_DATA, SER_RD_ACK, SER_RD_LOAD
	} serial_state_t;

	typedef struct packed {
		logic [3:0] height_high;
		logic [7:0] height_low;
		logic       test_enable;
		logic [3:0] pulse_max;
		logic [3:0] pulse_min;
		logic       oversampled;
		logic       pal_mode;
		logic [5:0] first_line;
		logic       scan_mode;
		logic       use_programmed;
		logic [5:0] last_line;
		logic [1:0] pulse_quota;
		logic       audio_low_freq;
		logic       audio_override;
	} config_regs_t;

	typedef struct packed {
		logic [1:0]    scl_sync;
		logic [1:0]    sda_sync;
		logic          scl_prev;
		logic          sda_prev;
		serial_state_t state;
		logic [3:0]    bit_cnt;
		logic [7:0]    shift;
		logic          rw;
		logic [7:0]    reg_ptr;
		logic          sda_oe;
		logic          audio_low_freq_eff;
		config_regs_t  regs;
	} regbank_state_t;

	typedef struct packed {
		logic [6:0] stage1;
		logic [6:0] stage2;
	} sync_state_t;

	typedef struct packed {
		logic       de_prev;
		logic       edge_seen;
		logic [15:0] win_cnt;
		logic [2:0] quality;
	} quality_state_t;
endpackage : video_rx_regs_pkg

//--- logic/link_status_if.sv
`timescale 1ns/1ps
`default_nettype none
interface link_status_if;
	logic       clock_present;
	logic       de_seen;
	logic       keys_loaded;
	logic       encrypted;
	logic       hsync_polarity;
	logic       vsync_polarity;
	logic       de_level;
	logic [2:0] quality;

	modport sync (output clock_present, de_seen, keys_loaded, encrypted,
		hsync_polarity, vsync_polarity, de_level);
	modport grade (input de_level, output quality);
	modport regs (input clock_present, de_seen, keys_loaded, encrypted,
		hsync_polarity, vsync_polarity, quality);
endinterface : link_status_if
`default_nettype wire

//--- logic/link_status_sync.sv
`timescale 1ns/1ps
`default_nettype none
module link_status_sync
	import video_rx_regs_pkg::*;
(
	input  wire logic       i_ref_clk,
	input  wire logic       i_rst,
	input  wire logic [6:0] i_raw,
	link_status_if.sync     status
);
	sync_state_t q;
	sync_state_t next_q;

	always_comb
	begin
		next_q = q;
		next_q.stage1 = i_raw;
		next_q.stage2 = q.stage1;
	end

	always_ff @(posedge i_ref_clk)
	begin
		if (i_rst)
			q <= '0;
		else
			q <= next_q;
	end

	assign status.clock_present  = q.stage2[0];
	assign status.de_seen        = q.stage2[1];
	assign status.keys_loaded    = q.stage2[2];
	assign status.encrypted      = q.stage2[3];
	assign status.hsync_polarity = q.stage2[4];
	assign status.vsync_polarity = q.stage2[5];
	assign status.de_level       = q.stage2[6];
endmodule : link_status_sync
`default_nettype wire

//--- logic/link_quality.sv
`timescale 1ns/1ps
`default_nettype none
`include "video_rx_regs_defs.svh"
module link_quality
	import video_rx_regs_pkg::*;
#(
	parameter logic [15:0] WINDOW = `QUALITY_WINDOW_CYCLES
)(
	input  wire logic   i_ref_clk,
	input  wire logic   i_rst,
	link_status_if.grade status
);
	quality_state_t q;
	quality_state_t next_q;

	// Each window with data-enable edges raises the grade until it saturates at 7, an idle one clears it
	always_comb
	begin
		next_q = q;
		next_q.de_prev = status.de_level;
		if (status.de_level && !q.de_prev)
			next_q.edge_seen = 1'b1;
		if (q.win_cnt == WINDOW - 16'h0001)
		begin
			next_q.win_cnt = '0;
			next_q.edge_seen = 1'b0;
			if (!(q.edge_seen || (status.de_level && !q.de_prev)))
				next_q.quality = '0;
			else if (q.quality != `QUALITY_MAX)
				next_q.quality = q.quality + 3'h1;
		end
		else
			next_q.win_cnt = q.win_cnt + 16'h0001;
	end

	always_ff @(posedge i_ref_clk)
	begin
		if (i_rst)
			q <= '0;
		else
			q <= next_q;
	end

	assign status.quality = q.quality;
endmodule : link_quality
`default_nettype wire

//--- logic/video_rx_status_config_regs.sv
`timescale 1ns/1ps
`default_nettype none
`include "video_rx_regs_defs.svh"
module video_rx_status_config_regs
	import video_rx_regs_pkg::*;
#(
	parameter logic [6:0]  DEVICE_ADDR    = `SERIAL_DEVICE_ADDR,
	parameter logic [15:0] QUALITY_WINDOW = `QUALITY_WINDOW_CYCLES
)(
	input  wire logic       i_ref_clk,
	input  wire logic       i_rst,
	input  wire logic       i_scl,
	input  wire logic       i_sda,
	output logic            o_sda,
	output logic            o_sda_oe,
	input  wire logic       i_link_clock_present,
	input  wire logic       i_link_data_enable_seen,
	input  wire logic       i_protection_keys_loaded,
	input  wire logic       i_content_encrypted,
	input  wire logic       i_hsync_polarity,
	input  wire logic       i_vsync_polarity,
	input  wire logic       i_link_de,
	input  wire logic       i_audio_auto_low_freq,
	output logic [11:0]     o_screen_height,
	output logic            o_test_enable,
	output logic [4:0]      o_copy_detect_pulse_max,
	output logic [4:0]      o_copy_detect_pulse_min,
	output logic            o_copy_detect_oversampled,
	output logic            o_copy_detect_pal_mode,
	output logic [5:0]      o_copy_detect_first_line,
	output logic [5:0]      o_copy_detect_last_line,
	output logic            o_copy_detect_scan_mode,
	output logic            o_copy_detect_use_programmed,
	output logic [1:0]      o_copy_detect_pulse_quota,
	output logic            o_copy_detect_quota_enable,
	output logic            o_audio_low_freq
);
	import video_rx_regs_pkg::*;

	link_status_if status ();

	link_status_sync u_sync (
		.i_ref_clk (i_ref_clk),
		.i_rst     (i_rst),
		.i_raw     ({i_link_de, i_vsync_polarity, i_hsync_polarity, i_content_encrypted,
			i_protection_keys_loaded, i_link_data_enable_seen, i_link_clock_present}),
		.status    (status.sync)
	);

	link_quality #(
		.WINDOW (QUALITY_WINDOW)
	) u_quality (
		.i_ref_clk (i_ref_clk),
		.i_rst     (i_rst),
		.status    (status.grade)
	);

	// Only writable offsets are decoded; status and unmapped offsets drop the byte
	function automatic config_regs_t write_reg(input config_regs_t r, input logic [7:0] a,
		input logic [7:0] d);
		config_regs_t w;
		w = r;
		case (a)
			`OFS_SCREEN_HEIGHT_HIGH:
				w.height_high = d[`POS_HEIGHT_HIGH +: 4];
			`OFS_SCREEN_HEIGHT_LOW:
				w.height_low = d;
			`OFS_TEST_CONTROL:
				w.test_enable = d[`POS_TEST_ENABLE];
			`OFS_COPY_DETECT_PULSE:
			begin
				w.pulse_max = d[`POS_PULSE_MAX +: 4];
				w.pulse_min = d[`POS_PULSE_MIN +: 4];
			end
			`OFS_COPY_DETECT_START:
			begin
				w.oversampled = d[`POS_OVERSAMPLED];
				w.pal_mode    = d[`POS_PAL_MODE];
				w.first_line  = d[`POS_FIRST_LINE +: 6];
			end
			`OFS_COPY_DETECT_END:
			begin
				w.scan_mode      = d[`POS_SCAN_MODE];
				w.use_programmed = d[`POS_USE_PROGRAMMED];
				w.last_line      = d[`POS_LAST_LINE +: 6];
			end
			`OFS_PULSE_LIMIT_AUDIO:
			begin
				w.pulse_quota    = d[`POS_PULSE_QUOTA +: 2];
				w.audio_low_freq = d[`POS_AUDIO_LOW_FREQ];
				w.audio_override = d[`POS_AUDIO_OVERRIDE];
			end
			default:
				w = r;
		endcase
		return w;
	endfunction : write_reg

	// Reset defaults, also serving as the detector's built-in settings
	function automatic config_regs_t default_regs();
		config_regs_t r;
		r = '0;
		r = write_reg(r, `OFS_SCREEN_HEIGHT_HIGH, `RST_SCREEN_HEIGHT_HIGH);
		r = write_reg(r, `OFS_SCREEN_HEIGHT_LOW, `RST_SCREEN_HEIGHT_LOW);
		r = write_reg(r, `OFS_TEST_CONTROL, `RST_TEST_CONTROL);
		r = write_reg(r, `OFS_COPY_DETECT_PULSE, `RST_COPY_DETECT_PULSE);
		r = write_reg(r, `OFS_COPY_DETECT_START, `RST_COPY_DETECT_START);
		r = write_reg(r, `OFS_COPY_DETECT_END, `RST_COPY_DETECT_END);
		r = write_reg(r, `OFS_PULSE_LIMIT_AUDIO, `RST_PULSE_LIMIT_AUDIO);
		return r;
	endfunction : default_regs

	function automatic logic [7:0] read_reg(input config_regs_t r, input logic [7:0] a,
		input logic [7:0] link_byte, input logic [7:0] prot_byte);
		logic [7:0] d;
		d = 8'h00;
		case (a)
			`OFS_SCREEN_HEIGHT_HIGH:
				d[`POS_HEIGHT_HIGH +: 4] = r.height_high;
			`OFS_SCREEN_HEIGHT_LOW:
				d = r.height_low;
			`OFS_TEST_CONTROL:
				d[`POS_TEST_ENABLE] = r.test_enable;
			`OFS_LINK_STATUS:
				d = link_byte;
			`OFS_PROTECTION_SYNC_STATUS:
				d = prot_byte;
			`OFS_COPY_DETECT_PULSE:
			begin
				d[`POS_PULSE_MAX +: 4] = r.pulse_max;
				d[`POS_PULSE_MIN +: 4] = r.pulse_min;
			end
			`OFS_COPY_DETECT_START:
			begin
				d[`POS_OVERSAMPLED]     = r.oversampled;
				d[`POS_PAL_MODE]        = r.pal_mode;
				d[`POS_FIRST_LINE +: 6] = r.first_line;
			end
			`OFS_COPY_DETECT_END:
			begin
				d[`POS_SCAN_MODE]      = r.scan_mode;
				d[`POS_USE_PROGRAMMED] = r.use_programmed;
				d[`POS_LAST_LINE +: 6] = r.last_line;
			end
			`OFS_PULSE_LIMIT_AUDIO:
			begin
				d[`POS_PULSE_QUOTA +: 2] = r.pulse_quota;
				d[`POS_AUDIO_LOW_FREQ]   = r.audio_low_freq;
				d[`POS_AUDIO_OVERRIDE]   = r.audio_override;
			end
			default:
				d = 8'h00;
		endcase
		return d;
	endfunction : read_reg

	localparam config_regs_t BUILTIN = default_regs();

	regbank_state_t q;
	regbank_state_t next_q;
	logic           scl;
	logic           sda;
	logic           scl_rise;
	logic           scl_fall;
	logic           start_seen;
	logic           stop_seen;
	logic [7:0]     link_byte;
	logic [7:0]     prot_byte;
	logic [7:0]     read_byte;

	assign scl        = q.scl_sync[1];
	assign sda        = q.sda_sync[1];
	assign scl_rise   = scl && !q.scl_prev;
	assign scl_fall   = !scl && q.scl_prev;
	assign start_seen = scl && q.scl_prev && q.sda_prev && !sda;
	assign stop_seen  = scl && q.scl_prev && !q.sda_prev && sda;

	always_comb
	begin
		link_byte = 8'h00;
		link_byte[`POS_DE_SEEN]       = status.de_seen;
		link_byte[`POS_CLOCK_PRESENT] = status.clock_present;
		link_byte[`POS_KEYS_LOADED]   = status.keys_loaded;
		link_byte[`POS_QUALITY +: 3]  = status.quality;
		prot_byte = 8'h00;
		prot_byte[`POS_ENCRYPTED]      = status.encrypted;
		prot_byte[`POS_HSYNC_POLARITY] = status.hsync_polarity;
		prot_byte[`POS_VSYNC_POLARITY] = status.vsync_polarity;
	end

	assign read_byte = read_reg(q.regs, q.reg_ptr, link_byte, prot_byte);

	always_comb
	begin
		next_q = q;
		next_q.scl_sync = {q.scl_sync[0], i_scl};
		next_q.sda_sync = {q.sda_sync[0], i_sda};
		next_q.scl_prev = scl;
		next_q.sda_prev = sda;
		next_q.audio_low_freq_eff = q.regs.audio_override ? q.regs.audio_low_freq
			: i_audio_auto_low_freq;
		if (start_seen)
		begin
			next_q.state   = SER_DEV_ADDR;
			next_q.bit_cnt = '0;
			next_q.sda_oe  = 1'b0;
		end
		else if (stop_seen)
		begin
			next_q.state  = SER_IDLE;
			next_q.sda_oe = 1'b0;
		end
		else
		begin
			case (q.state)
				SER_IDLE:
					next_q.sda_oe = 1'b0;
				SER_DEV_ADDR, SER_REG_ADDR, SER_WR_DATA:
				begin
					if (scl_rise)
					begin
						next_q.shift   = {q.shift[6:0], sda};
						next_q.bit_cnt = q.bit_cnt + 4'h1;
					end
					else if (scl_fall && q.bit_cnt == 4'h8)
					begin
						next_q.bit_cnt = '0;
						next_q.sda_oe  = 1'b1;
						if (q.state == SER_DEV_ADDR)
						begin
							if (q.shift[7:1] == DEVICE_ADDR)
							begin
								next_q.rw    = q.shift[0];
								next_q.state = SER_ADDR_ACK;
							end
							else
							begin
								next_q.sda_oe = 1'b0;
								next_q.state  = SER_IDLE;
							end
						end
						else if (q.state == SER_REG_ADDR)
						begin
							next_q.reg_ptr = q.shift;
							next_q.state   = SER_REG_ACK;
						end
						else
						begin
							next_q.regs    = write_reg(q.regs, q.reg_ptr, q.shift);
							next_q.reg_ptr = q.reg_ptr + 8'h01;
							next_q.state   = SER_WR_ACK;
						end
					end
				end
				SER_ADDR_ACK:
				begin
					if (scl_fall)
					begin
						next_q.bit_cnt = '0;
						if (q.rw)
						begin
							next_q.shift  = read_byte;
							next_q.sda_oe = !read_byte[7];
							next_q.state  = SER_RD_DATA;
						end
						else
						begin
							next_q.sda_oe = 1'b0;
							next_q.state  = SER_REG_ADDR;
						end
					end
				end
				SER_REG_ACK, SER_WR_ACK:
				begin
					if (scl_fall)
					begin
						next_q.sda_oe  = 1'b0;
						next_q.bit_cnt = '0;
						next_q.state   = SER_WR_DATA;
					end
				end
				SER_RD_DATA:
				begin
					if (scl_rise)
						next_q.bit_cnt = q.bit_cnt + 4'h1;
					else if (scl_fall)
					begin
						if (q.bit_cnt == 4'h8)
						begin
							next_q.sda_oe  = 1'b0;
							next_q.reg_ptr = q.reg_ptr + 8'h01;
							next_q.state   = SER_RD_ACK;
						end
						else
						begin
							next_q.shift  = {q.shift[6:0], 1'b0};
							next_q.sda_oe = !q.shift[6];
						end
					end
				end
				SER_RD_ACK:
				begin
					if (scl_rise)
						next_q.state = sda ? SER_IDLE : SER_RD_LOAD;
				end
				SER_RD_LOAD:
				begin
					if (scl_fall)
					begin
						next_q.bit_cnt = '0;
						next_q.shift   = read_byte;
						next_q.sda_oe  = !read_byte[7];
						next_q.state   = SER_RD_DATA;
					end
				end
				default:
				begin
					next_q.state  = SER_IDLE;
					next_q.sda_oe = 1'b0;
				end
			endcase
		end
	end

	always_ff @(posedge i_ref_clk)
	begin
		if (i_rst)
		begin
			q       <= '0;
			q.state <= SER_IDLE;
			{q.scl_sync, q.sda_sync, q.scl_prev, q.sda_prev} <= 6'h3f;
			q.regs  <= default_regs();
		end
		else
			q <= next_q;
	end

	assign o_sda    = 1'b0;
	assign o_sda_oe = q.sda_oe;

	assign o_screen_height = {q.regs.height_high, q.regs.height_low};
	assign o_test_enable   = q.regs.test_enable;

	// Programmed or built-in detector settings, widths doubled when oversampled
	config_regs_t cd;
	assign cd = q.regs.use_programmed ? q.regs : BUILTIN;

	assign o_copy_detect_pulse_max = q.regs.oversampled ? {cd.pulse_max, 1'b0}
		: {1'b0, cd.pulse_max};
	assign o_copy_detect_pulse_min = q.regs.oversampled ? {cd.pulse_min, 1'b0}
		: {1'b0, cd.pulse_min};
	assign o_copy_detect_first_line     = cd.first_line;
	assign o_copy_detect_last_line      = cd.last_line;
	assign o_copy_detect_oversampled    = q.regs.oversampled;
	assign o_copy_detect_pal_mode       = q.regs.pal_mode;
	assign o_copy_detect_scan_mode      = q.regs.scan_mode;
	assign o_copy_detect_use_programmed = q.regs.use_programmed;
	assign o_copy_detect_pulse_quota    = q.regs.pulse_quota;
	assign o_copy_detect_quota_enable   = !q.regs.scan_mode;
	assign o_audio_low_freq             = q.audio_low_freq_eff;
endmodule : video_rx_status_config_regs
`default_nettype wire

//--- sim/serial_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module serial_host_model (
	input  wire logic i_ref_clk,
	input  wire logic i_dev_pull,
	output var logic  o_scl,
	output logic      o_sda
);
	logic sda_drv;
	// Open-drain wire with pull-up: released by both sides reads high
	assign o_sda = sda_drv & ~i_dev_pull;
	initial
	begin
		o_scl = 1'b1;
		sda_drv = 1'b1;
	end
	task automatic tick(input int n);
		repeat (n) @(posedge i_ref_clk);
		#2;
	endtask : tick
	// Data moves while the clock is high: start (1 then 0) or stop (0 then 1)
	task automatic edge2(input logic a, input logic b);
		sda_drv = a;
		tick(6);
		o_scl = 1'b1;
		tick(6);
		sda_drv = b;
		tick(6);
	endtask : edge2
	task automatic start_cond();
		edge2(1'b1, 1'b0);
		o_scl = 1'b0;
		tick(6);
	endtask : start_cond
	// Eight bits MSB first, then the acknowledge slot
	task automatic xfer(input logic [7:0] tx, input logic ack_bit, output logic [7:0] rx,
		output logic acked);
		logic [8:0] b;
		b = {tx, ack_bit};
		for (int i = 8; i >= 0; i--)
		begin
			sda_drv = b[i];
			tick(6);
			o_scl = 1'b1;
			tick(6);
			if (i > 0)
				rx = {rx[6:0], o_sda};
			else
				acked = ~o_sda;
			o_scl = 1'b0;
			tick(1);
		end
	endtask : xfer
	// One register access; a read ends with a NACK from the host
	task automatic xact(input logic [6:0] dev, input logic [7:0] adr, input logic [7:0] dat,
		input logic rd, output logic [7:0] q, output logic ok);
		logic k;
		start_cond();
		xfer({dev, 1'b0}, 1'b1, q, ok);
		xfer(adr, 1'b1, q, k);
		ok &= k;
		if (rd)
		begin
			start_cond();
			xfer({dev, 1'b1}, 1'b1, q, k);
			ok &= k;
		end
		xfer(rd ? 8'hff : dat, 1'b1, q, k);
		if (!rd)
			ok &= k;
		edge2(1'b0, 1'b1);
	endtask : xact
	// Two data bytes in one access; on a read the host acknowledges the first
	task automatic xact2(input logic [6:0] dev, input logic [7:0] adr, input logic [15:0] dat,
		input logic rd, output logic [15:0] q, output logic ok);
		logic k;
		logic [7:0] b;
		start_cond();
		xfer({dev, 1'b0}, 1'b1, b, ok);
		xfer(adr, 1'b1, b, k);
		ok &= k;
		if (rd)
		begin
			start_cond();
			xfer({dev, 1'b1}, 1'b1, b, k);
			ok &= k;
		end
		xfer(rd ? 8'hff : dat[15:8], !rd, q[15:8], k);
		ok &= k;
		xfer(rd ? 8'hff : dat[7:0], 1'b1, q[7:0], k);
		if (!rd)
			ok &= k;
		edge2(1'b0, 1'b1);
	endtask : xact2
endmodule : serial_host_model
`default_nettype wire

//--- sim/video_rx_status_config_regs_chk.sv
`timescale 1ns/1ps
`default_nettype none
module video_rx_status_config_regs_chk #(
	parameter logic [15:0] QUALITY_WINDOW = 16'h0400
)(
	input wire logic        i_ref_clk,
	input wire logic        i_rst,
	input wire logic        i_scl,
	input wire logic        o_sda_oe,
	input wire logic [11:0] o_screen_height,
	input wire logic        o_test_enable,
	input wire logic [4:0]  o_copy_detect_pulse_max,
	input wire logic [4:0]  o_copy_detect_pulse_min,
	input wire logic        o_copy_detect_oversampled,
	input wire logic [5:0]  o_copy_detect_first_line,
	input wire logic [5:0]  o_copy_detect_last_line,
	input wire logic        o_copy_detect_scan_mode,
	input wire logic        o_copy_detect_use_programmed,
	input wire logic [1:0]  o_copy_detect_pulse_quota,
	input wire logic        o_copy_detect_quota_enable
);
	default clocking cb @(posedge i_ref_clk);
	endclocking
	default disable iff (i_rst);
	logic [9:0]  w;
	logic [11:0] lines;
	logic [36:0] cfg;
	logic        usep;
	logic        over;
	assign w = {o_copy_detect_pulse_max, o_copy_detect_pulse_min};
	assign lines = {o_copy_detect_first_line, o_copy_detect_last_line};
	assign cfg = {o_screen_height, o_test_enable, w, lines, o_copy_detect_pulse_quota};
	assign usep = o_copy_detect_use_programmed;
	assign over = o_copy_detect_oversampled;
	property p_reset_height;
		$fell(i_rst) |-> o_screen_height == 12'h2d0 && !o_test_enable;
	endproperty
	a_reset_height: assert property (p_reset_height) else $error("height not default");
	property p_reset_detect;
		$fell(i_rst) |-> o_copy_detect_scan_mode && !usep && !over
			&& o_copy_detect_pulse_quota == 2'h2;
	endproperty
	a_reset_detect: assert property (p_reset_detect) else $error("detector not default");
	property p_builtin_lines;
		!usep |-> lines == {6'h0d, 6'h15};
	endproperty
	a_builtin_lines: assert property (p_builtin_lines) else $error("built-in lines");
	property p_builtin_widths;
		!usep && !over |-> w == {5'h09, 5'h06};
	endproperty
	a_builtin_widths: assert property (p_builtin_widths) else $error("built-in widths");
	property p_oversample;
		!usep && over |-> w == {5'h12, 5'h0c};
	endproperty
	a_oversample: assert property (p_oversample) else $error("oversampled widths");
	property p_prog_range;
		usep && !over |-> !w[9] && !w[4];
	endproperty
	a_prog_range: assert property (p_prog_range) else $error("programmed width range");
	property p_quota_en;
		o_copy_detect_quota_enable == !o_copy_detect_scan_mode;
	endproperty
	a_quota_en: assert property (p_quota_en) else $error("quota enable vs mode");
	property p_cfg_hold;
		i_scl [*5] |-> $stable(cfg);
	endproperty
	a_cfg_hold: assert property (p_cfg_hold) else $error("config moved mid bit");
	property p_oe_scl_low;
		$changed(o_sda_oe) |-> !i_scl;
	endproperty
	a_oe_scl_low: assert property (p_oe_scl_low) else $error("data moved with clock high");
	c_test_on: cover property ($rose(o_test_enable));
	c_prog_over: cover property (usep && over);
	c_ack: cover property ($rose(o_sda_oe));
endmodule : video_rx_status_config_regs_chk
bind video_rx_status_config_regs video_rx_status_config_regs_chk #(
	.QUALITY_WINDOW(QUALITY_WINDOW)
) u_chk (.i_ref_clk, .i_rst, .i_scl, .o_sda_oe, .o_screen_height, .o_test_enable,
	.o_copy_detect_pulse_max, .o_copy_detect_pulse_min, .o_copy_detect_oversampled,
	.o_copy_detect_first_line, .o_copy_detect_last_line, .o_copy_detect_scan_mode,
	.o_copy_detect_use_programmed, .o_copy_detect_pulse_quota, .o_copy_detect_quota_enable);
`default_nettype wire

//--- sim/video_rx_status_config_regs_tb.sv
`timescale 1ns/1ps
`default_nettype none
module video_rx_status_config_regs_tb;
	import video_rx_regs_pkg::*;
	localparam logic [6:0] DEV = 7'h4c;
	localparam logic [7:0] DEF [9] = '{8'h02, 8'hd0, 8'h00, 8'h00, 8'h00, 8'h96, 8'h0d,
		8'h95, 8'h80};
	localparam logic [7:0] ADR [6] = '{8'h2c, 8'h2d, 8'h31, 8'h32, 8'h33, 8'h34};
	localparam logic [7:0] MSK [6] = '{8'h0f, 8'hff, 8'hff, 8'hff, 8'hff, 8'hf0};
	logic        i_ref_clk, i_rst, i_scl, i_sda, o_sda, o_sda_oe;
	logic        de, de_tog, aut, ok, test_en, over, pal, scan, usep, qen, alf;
	logic [5:0]  st, first, last;
	logic [11:0] o_screen_height;
	logic [4:0]  pmax, pmin;
	logic [1:0]  quota;
	logic [7:0]  q;
	logic [15:0] q2;
	logic [7:0]  rv [6];
	int          seed = 32'hec8f;
	int          bad_count = 0;
	int          n_tests = 0;
	video_rx_status_config_regs #(.QUALITY_WINDOW(16'h0010)) u_dut (
		.i_ref_clk, .i_rst, .i_scl, .i_sda, .o_sda, .o_sda_oe,
		.i_link_clock_present(st[4]), .i_link_data_enable_seen(st[5]),
		.i_protection_keys_loaded(st[3]), .i_content_encrypted(st[2]),
		.i_hsync_polarity(st[1]), .i_vsync_polarity(st[0]), .i_link_de(de),
		.i_audio_auto_low_freq(aut), .o_screen_height, .o_test_enable(test_en),
		.o_copy_detect_pulse_max(pmax), .o_copy_detect_pulse_min(pmin),
		.o_copy_detect_oversampled(over), .o_copy_detect_pal_mode(pal),
		.o_copy_detect_first_line(first), .o_copy_detect_last_line(last),
		.o_copy_detect_scan_mode(scan), .o_copy_detect_use_programmed(usep),
		.o_copy_detect_pulse_quota(quota), .o_copy_detect_quota_enable(qen),
		.o_audio_low_freq(alf));
	serial_host_model u_host (.i_ref_clk, .i_dev_pull(o_sda_oe), .o_scl(i_scl), .o_sda(i_sda));
	initial
	begin
		i_ref_clk = 1'b0;
		forever #12.5 i_ref_clk = ~i_ref_clk;
	end
	// Data-enable toggles every cycle while enabled
	always @(posedge i_ref_clk)
		de <= #2 de_tog & ~de;
	task automatic tick(input int n);
		repeat (n) @(posedge i_ref_clk);
		#2;
	endtask : tick
	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp)
		begin
			bad_count++;
			$display("[FAIL] %0t got %h expected %h", $time, got, exp);
		end
	endtask : check
	task automatic rchk(input logic [7:0] a, input logic [7:0] e);
		u_host.xact(DEV, a, 8'h00, 1'b1, q, ok);
		check({ok, q}, {1'b1, e});
	endtask : rchk
	function automatic logic [9:0] exp_w(input logic [7:0] w, input logic [7:0] c,
		input logic [7:0] m);
		logic [4:0] mx, mn;
		mx = m[6] ? {1'b0, w[7:4]} : 5'h09;
		mn = m[6] ? {1'b0, w[3:0]} : 5'h06;
		return {mx << c[7], mn << c[7]};
	endfunction : exp_w
	task automatic defaults();
		for (int i = 0; i < 9; i++)
			rchk(8'h2c + 8'(i), DEF[i]);
		check({o_screen_height, test_en, o_sda}, {12'h2d0, 2'b00});
		$display("defaults done");
	endtask : defaults
	task automatic final_report();
		$display("comparisons %0d mismatches %0d", n_tests, bad_count);
		if (bad_count == 0 && n_tests > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask : final_report
	initial
	begin
		repeat (90000) @(posedge i_ref_clk);
		$display("[FAIL] %0t watchdog expired", $time);
		bad_count++;
		final_report();
	end
	initial
	begin
		i_rst = 1'b1;
		st = '0;
		de_tog = 1'b0;
		aut = 1'b0;
		tick(16);
		i_rst = 1'b0;
		tick(4);
		defaults();
		u_host.xact(DEV, 8'h2e, 8'h80, 1'b0, q, ok);
		check({ok, test_en}, 2'b11);
		u_host.xact(7'h4d, 8'h2e, 8'h00, 1'b0, q, ok);
		check({ok, test_en}, 2'b01);
		u_host.xact(DEV, 8'h40, 8'h5a, 1'b0, q, ok);
		check(ok, 1'b1);
		rchk(8'h40, 8'h00);
		$display("refusals done");
		for (int n = 0; n < 6; n++)
		begin
			for (int j = 0; j < 6; j++)
				rv[j] = (n == 0) ? 8'hff : (n == 1) ? 8'h80 : 8'($random(seed));
			aut = 1'($random(seed));
			// Pixel clock is taken as slow, so low-frequency mode may be set
			for (int j = 0; j < 6; j++)
				u_host.xact(DEV, ADR[j], rv[j], 1'b0, q, ok);
			check({o_screen_height, test_en}, {rv[0][3:0], rv[1], 1'b1});
			check({pmax, pmin}, exp_w(rv[2], rv[3], rv[4]));
			check({first, last}, rv[4][6] ? {rv[3][5:0], rv[4][5:0]} : 12'h355);
			check({over, pal, scan, usep, quota, qen},
				{rv[3][7:6], rv[4][7:6], rv[5][7:6], ~rv[4][7]});
			check(alf, rv[5][4] ? rv[5][5] : aut);
			aut = ~aut;
			tick(2);
			check(alf, rv[5][4] ? rv[5][5] : aut);
			for (int j = 0; j < 6; j++)
				rchk(ADR[j], rv[j] & MSK[j]);
		end
		$display("config done");
		// Pointer steps between bytes of one access, for writes and reads
		rv[0] = 8'($random(seed));
		rv[1] = 8'($random(seed));
		u_host.xact2(DEV, 8'h2c, {rv[0], rv[1]}, 1'b0, q2, ok);
		check({ok, o_screen_height}, {1'b1, rv[0][3:0], rv[1]});
		u_host.xact2(DEV, 8'h2c, 16'hffff, 1'b1, q2, ok);
		check({ok, q2}, {1'b1, rv[0] & 8'h0f, rv[1]});
		$display("burst done");
		for (int n = 0; n < 6; n++)
		begin
			st = 6'($random(seed));
			de_tog = n[0];
			tick(200);
			u_host.xact(DEV, 8'h2f, 8'hff, 1'b0, q, ok);
			rchk(8'h2f, {1'b0, st[5:4], 1'b0, st[3], de_tog ? 3'h7 : 3'h0});
			rchk(8'h30, {1'b0, st[2:0], 4'h0});
			st[2] = ~st[2];
			rchk(8'h30, {1'b0, st[2:0], 4'h0});
		end
		$display("status done");
		st = '0;
		de_tog = 1'b0;
		i_rst = 1'b1;
		tick(16);
		i_rst = 1'b0;
		tick(4);
		defaults();
		final_report();
	end
endmodule : video_rx_status_config_regs_tb
`default_nettype wire
